// >>> design/ted_map.svh
// Purpose: register offsets, field positions, reset values and codes
// Assumes: included by its bare name from the design files
// Notes:   definitions only
`ifndef TED_MAP_SVH
`define TED_MAP_SVH

// register byte offsets, decoded on haddr[7:0]
`define TED_OFS_TASK_PID 8'h00
`define TED_OFS_TASK_IND 8'h04
`define TED_OFS_TASK_VAL 8'h08
`define TED_OFS_CFG      8'h0c
`define TED_OFS_CMD      8'h10
`define TED_OFS_RSP_PID  8'h14
`define TED_OFS_RSP_IND  8'h18
`define TED_OFS_RSP_VAL  8'h1c
`define TED_OFS_STATUS   8'h20

// field positions
`define TED_ID_MSB     15
`define TED_ID_LSB     12
`define TED_PNU_MSB    10
`define TED_WR_BIT     8
`define TED_FLD_BIT    9
`define TED_CFG_LEN_MSB 6
`define TED_CFG_PT_LSB 8
`define TED_CMD_GO_BIT 0
`define TED_CMD_CLR_BIT 1

// reset values
`define TED_CFG_RST    7'h7f
`define TED_PT_RST     2'h1

// protocol codes
`define TED_VAR_LEN    7'h7f
`define TED_TASK_TEXT  4'hf
`define TED_RSP_TEXT   4'hf
`define TED_RSP_ERR    4'h7
`define TED_Y_ALL      8'hff
`define TED_Y_NONE     8'h00

// error numbers returned in the value word
`define TED_ERR_TASK   16'h0001
`define TED_ERR_FIXLEN 16'h0002
`define TED_ERR_Y_ALL  16'h0003
`define TED_ERR_RANGE  16'h0004
`define TED_ERR_NOFLD  16'h0005
`define TED_ERR_NOTEXT 16'h0006

`endif

// >>> design/ted_pkg.sv
// Purpose: types shared by the text element task decoder
// Assumes: nothing
// Notes:   constants live in ted_map.svh
package ted_pkg;

  typedef enum logic [1:0] {
    TED_PT_OTHER    = 2'b00,
    TED_PT_ARRAY    = 2'b01,
    TED_PT_UNSIGNED = 2'b10,
    TED_PT_BITFIELD = 2'b11
  } ted_ptype_t;

  typedef enum logic [1:0] {
    TED_ST_IDLE   = 2'b00,
    TED_ST_CHECK  = 2'b01,
    TED_ST_ACCESS = 2'b10,
    TED_ST_RESP   = 2'b11
  } ted_state_t;

  typedef struct packed {
    logic [15:0] pid;
    logic [15:0] index_word;
    logic [15:0] val;
  } ted_word3_t;

  typedef struct packed {
    logic        ok;
    logic        field;
    logic        write;
    logic [15:0] err;
  } ted_decode_t;

endpackage : ted_pkg

// >>> design/ted_task_classify.sv
// Purpose: classify one task as a legal text element access or an error
// Assumes: task words stable while the caller samples the result
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "ted_map.svh"

module ted_task_classify (
  // task and configuration
  input  wire ted_pkg::ted_word3_t  taskIn,
  input  wire logic [6:0]           lenSetting,
  input  wire ted_pkg::ted_ptype_t  ptype,
  // result
  output var  ted_pkg::ted_decode_t dec
);
  import ted_pkg::*;

  always_comb begin
    logic [7:0] y;
    y         = taskIn.index_word[7:0];
    dec       = '0;
    // only bits 9 and 8 of the high byte steer; bits 10..15 are never looked at
    dec.field = taskIn.index_word[`TED_FLD_BIT];
    dec.write = taskIn.index_word[`TED_WR_BIT];
    if (taskIn.pid[`TED_ID_MSB:`TED_ID_LSB] != `TED_TASK_TEXT) begin
      dec.err = `TED_ERR_TASK;
    end else if (lenSetting != `TED_VAR_LEN) begin
      dec.err = `TED_ERR_FIXLEN;
    end else if (y == `TED_Y_ALL) begin
      dec.err = `TED_ERR_Y_ALL;
    end else if (y == `TED_Y_NONE) begin
      dec.err = `TED_ERR_RANGE;
    end else if (dec.field && ptype != TED_PT_ARRAY) begin
      dec.err = `TED_ERR_NOFLD;
    end else if (ptype == TED_PT_OTHER) begin
      dec.err = `TED_ERR_NOTEXT;
    end else begin
      dec.ok = 1'b1;
    end
  end

endmodule : ted_task_classify
`default_nettype wire

// >>> design/ted_text_element_decoder.sv
// Purpose: AHB-Lite slave that executes text element read/write tasks
// Assumes: single-word AHB transfers from one master, one clock domain
// Notes:   zero wait states; read data is sampled at the address phase
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ted_map.svh"

//////////////////////////////////////////////////////////////////////////////
module ted_text_element_decoder (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic [31:0] hrdata,
  output var  logic        hresp
);
  import ted_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state

  ted_state_t  state_r;
  ted_word3_t  task_r;
  ted_word3_t  rsp_r;
  ted_decode_t dec;
  ted_decode_t decR_r;
  ted_ptype_t  ptype_r;
  logic [6:0]  lenSetting_r;
  logic        done_r;
  logic        lastErr_r;
  logic        wrPend_r;
  logic [7:0]  wrAddr_r;
  logic [15:0] memRd_r;
  logic [8:0]  memAddr;
  logic        addrPhase;
  logic        busWr;
  logic        goPulse;
  logic        clrPulse;
  logic        idle;
  logic [31:0] rdMux;

  // two fields of 256 slots; slot 0 and 255 are never legal targets
  logic [15:0] textMem [0:511];

  //////////////////////////////////////////////////////////////////////////////
  // bus decode

  assign addrPhase = hsel & htrans[1] & hready;
  assign busWr     = wrPend_r;
  assign idle      = (state_r == TED_ST_IDLE);
  // new tasks only start from idle; a go during a task is dropped
  assign goPulse   = busWr && wrAddr_r == `TED_OFS_CMD && hwdata[`TED_CMD_GO_BIT] && idle;
  assign clrPulse  = busWr && wrAddr_r == `TED_OFS_CMD && hwdata[`TED_CMD_CLR_BIT];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
    end else if (hready) begin
      wrPend_r <= addrPhase & hwrite;
      wrAddr_r <= haddr[7:0];
    end
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (haddr[7:0])
      `TED_OFS_TASK_PID: rdMux = {16'h0000, task_r.pid};
      `TED_OFS_TASK_IND: rdMux = {16'h0000, task_r.index_word};
      `TED_OFS_TASK_VAL: rdMux = {16'h0000, task_r.val};
      `TED_OFS_CFG:      rdMux = {22'h00_0000, ptype_r, 1'b0, lenSetting_r};
      `TED_OFS_RSP_PID:  rdMux = {16'h0000, rsp_r.pid};
      `TED_OFS_RSP_IND:  rdMux = {16'h0000, rsp_r.index_word};
      `TED_OFS_RSP_VAL:  rdMux = {16'h0000, rsp_r.val};
      `TED_OFS_STATUS:   rdMux = {29'h0000_0000, lastErr_r, done_r, ~idle};
      default:           rdMux = 32'h0000_0000;
    endcase
  end

  // read data is latched at the address phase so hrdata is a flop output
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= rdMux;
    end
  end

  // the slave never stretches a transfer and never errors
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // software registers

  // task words are frozen while a task runs so the echo stays coherent
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      task_r <= '0;
    end else if (busWr && idle) begin
      unique case (wrAddr_r)
        `TED_OFS_TASK_PID: task_r.pid <= hwdata[15:0];
        `TED_OFS_TASK_IND: task_r.index_word <= hwdata[15:0];
        `TED_OFS_TASK_VAL: task_r.val <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lenSetting_r <= `TED_CFG_RST;
      ptype_r      <= ted_ptype_t'(`TED_PT_RST);
    end else if (busWr && idle && wrAddr_r == `TED_OFS_CFG) begin
      lenSetting_r <= hwdata[`TED_CFG_LEN_MSB:0];
      ptype_r      <= ted_ptype_t'(hwdata[`TED_CFG_PT_LSB+1:`TED_CFG_PT_LSB]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // task sequencing

  ted_task_classify u_classify (
    .taskIn     (task_r),
    .lenSetting (lenSetting_r),
    .ptype      (ptype_r),
    .dec        (dec)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= TED_ST_IDLE;
    end else begin
      unique case (state_r)
        TED_ST_IDLE:   if (goPulse) state_r <= TED_ST_CHECK;
        TED_ST_CHECK:  state_r <= dec.ok ? TED_ST_ACCESS : TED_ST_RESP;
        TED_ST_ACCESS: state_r <= TED_ST_RESP;
        TED_ST_RESP:   state_r <= TED_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      decR_r <= '0;
    end else if (state_r == TED_ST_CHECK) begin
      decR_r <= dec;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // text store

  // y is used directly as the slot; for the per-value field the master has
  // already added one to the parameter value, so slot y holds value y-1
  assign memAddr = {decR_r.field, task_r.index_word[7:0]};

  always_ff @(posedge clk) begin
    if (state_r == TED_ST_ACCESS && decR_r.write) begin
      textMem[memAddr] <= task_r.val;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      memRd_r <= 16'h0000;
    end else if (state_r == TED_ST_ACCESS) begin
      memRd_r <= textMem[memAddr];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // response

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_r <= '0;
    end else if (state_r == TED_ST_RESP) begin
      // parameter number, toggle bit and whole index are echoed untouched
      rsp_r.pid[11:0] <= task_r.pid[11:0];
      rsp_r.index_word       <= task_r.index_word;
      if (decR_r.ok) begin
        rsp_r.pid[15:12] <= `TED_RSP_TEXT;
        rsp_r.val        <= decR_r.write ? task_r.val : memRd_r;
      end else begin
        rsp_r.pid[15:12] <= `TED_RSP_ERR;
        rsp_r.val        <= decR_r.err;
      end
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_r    <= 1'b0;
      lastErr_r <= 1'b0;
    end else if (state_r == TED_ST_RESP) begin
      done_r    <= 1'b1;
      lastErr_r <= ~decR_r.ok;
    end else if (clrPulse) begin
      done_r    <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_fixlen_error: assert property (
    state_r == TED_ST_CHECK && lenSetting_r != `TED_VAR_LEN
    |=> !decR_r.ok && decR_r.err != 16'h0000
  ) else $error("fixed length task not refused");

  a_y_all_error: assert property (
    state_r == TED_ST_CHECK && task_r.index_word[7:0] == `TED_Y_ALL
    |=> ##1 rsp_r.pid[15:12] == `TED_RSP_ERR
  ) else $error("low byte 255 not answered with error id");

  a_legal_accepted: assert property (
    state_r == TED_ST_CHECK && task_r.pid[15:12] == `TED_TASK_TEXT
    && lenSetting_r == `TED_VAR_LEN && task_r.index_word[7:0] != `TED_Y_ALL
    && task_r.index_word[7:0] != `TED_Y_NONE && ptype_r == TED_PT_ARRAY
    |=> decR_r.ok
  ) else $error("legal text task refused");

  a_second_needs_array: assert property (
    state_r == TED_ST_CHECK && task_r.index_word[`TED_FLD_BIT]
    && ptype_r != TED_PT_ARRAY
    |=> !decR_r.ok
  ) else $error("secondary field accepted for non-array");

  a_field_select: assert property (
    state_r == TED_ST_CHECK
    |=> decR_r.field == $past(task_r.index_word[9]) && decR_r.write == $past(task_r.index_word[8])
  ) else $error("field or direction taken from wrong index bit");

  a_ok_resp_id: assert property (
    state_r == TED_ST_RESP && decR_r.ok && !decR_r.write
    |=> rsp_r.pid[15:12] == `TED_RSP_TEXT && rsp_r.val == $past(memRd_r)
  ) else $error("successful read not answered with element");

  a_echo_words: assert property (
    state_r == TED_ST_RESP
    |=> rsp_r.index_word == $past(task_r.index_word) && rsp_r.pid[11:0] == $past(task_r.pid[11:0])
  ) else $error("response does not echo task");

  a_write_stored: assert property (
    state_r == TED_ST_ACCESS && decR_r.write
    |=> textMem[$past(memAddr)] == $past(task_r.val)
  ) else $error("text element not written");

  a_task_done: assert property (
    goPulse |=> ##[1:3] (state_r == TED_ST_IDLE && done_r)
  ) else $error("task did not complete in time");

  // a legal task with junk in index bits 15..10 must still be taken, since a
  // master that does not know our family may leave them set
  a_high_ignored: assert property (
    state_r == TED_ST_CHECK && task_r.pid[15:12] == `TED_TASK_TEXT
    && lenSetting_r == `TED_VAR_LEN && task_r.index_word[7:0] != `TED_Y_ALL
    && task_r.index_word[7:0] != `TED_Y_NONE && ptype_r == TED_PT_ARRAY
    && task_r.index_word[15:10] != 6'h00
    |=> decR_r.ok
  ) else $error("converter specific index bits were interpreted");

  a_fixlen_resp: assert property (
    state_r == TED_ST_CHECK && lenSetting_r != `TED_VAR_LEN
    |=> ##1 rsp_r.pid[15:12] == `TED_RSP_ERR
  ) else $error("fixed length task answered without error id");

  a_zero_refused: assert property (
    state_r == TED_ST_CHECK && task_r.index_word[7:0] == `TED_Y_NONE
    |=> !decR_r.ok
  ) else $error("element zero accepted");

  a_second_written: assert property (
    state_r == TED_ST_ACCESS && decR_r.write && decR_r.field
    |=> textMem[{1'b1, $past(task_r.index_word[7:0])}] == $past(task_r.val)
  ) else $error("secondary text element not written");

  a_no_text_type: assert property (
    state_r == TED_ST_CHECK && ptype_r == TED_PT_OTHER
    |=> !decR_r.ok
  ) else $error("text task accepted for type without text");

  a_write_echo: assert property (
    state_r == TED_ST_RESP && decR_r.ok && decR_r.write
    |=> rsp_r.pid[15:12] == `TED_RSP_TEXT && rsp_r.val == $past(task_r.val)
  ) else $error("successful write not answered with element");

  // a refused task must never reach the store, or it could clobber a slot
  a_err_no_access: assert property (
    state_r == TED_ST_ACCESS |-> decR_r.ok
  ) else $error("refused task reached the text store");

  a_task_frozen: assert property (
    !idle |=> $stable(task_r)
  ) else $error("task words changed while a task ran");

  a_done_set: assert property (
    state_r == TED_ST_RESP |=> done_r && idle
  ) else $error("response not flagged as done");

  a_y_all_code: assert property (
    state_r == TED_ST_CHECK && task_r.pid[15:12] == `TED_TASK_TEXT
    && lenSetting_r == `TED_VAR_LEN && task_r.index_word[7:0] == `TED_Y_ALL
    |=> decR_r.err == `TED_ERR_Y_ALL
  ) else $error("low byte 255 given wrong error number");

  c_read_ok:   cover property (state_r == TED_ST_RESP && decR_r.ok && !decR_r.write);
  c_write_ok:  cover property (state_r == TED_ST_RESP && decR_r.ok && decR_r.write);
  c_fixlen:    cover property (state_r == TED_ST_RESP && decR_r.err == `TED_ERR_FIXLEN);
  c_secondary: cover property (state_r == TED_ST_ACCESS && decR_r.field);
  c_high_bits: cover property (state_r == TED_ST_CHECK && task_r.index_word[15:10] != 6'h00);

endmodule : ted_text_element_decoder
`default_nettype wire

// >>> verif/tb_top.sv
// Purpose: self-checking bench for the text element task decoder
// Assumes: one clock, slave answers through hreadyout
// Notes:   rows run in order; later reads rely on earlier writes
`timescale 1ns/1ps
`default_nettype none
`include "ted_map.svh"

module tb_top;
  import ted_pkg::*;

  typedef struct packed {
    logic [15:0] pid;
    logic [15:0] index_word;
    logic [15:0] val;
    logic [9:0]  cfg;
    logic [3:0]  id;
    logic [15:0] rv;
  } ted_row_t;

  logic        clk;
  logic        arst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        hung;
  logic [31:0] d;
  logic [31:0] st;
  int          num_errors;
  int          comparisons;

  // cfg is {type, 0, length}; secondary y is the value plus one
  ted_row_t rows [15] = '{
    '{16'hf123, 16'h0101, 16'h1234, 10'h17f, 4'hf, 16'h1234},
    '{16'hf7ff, 16'h01fe, 16'hbeef, 10'h37f, 4'hf, 16'hbeef},
    '{16'hf001, 16'h0305, 16'h0a5a, 10'h17f, 4'hf, 16'h0a5a},
    '{16'hf802, 16'h0105, 16'h5555, 10'h27f, 4'hf, 16'h5555},
    '{16'hf003, 16'h0205, 16'h0000, 10'h17f, 4'hf, 16'h0a5a},
    '{16'hf004, 16'h0005, 16'h0000, 10'h17f, 4'hf, 16'h5555},
    '{16'hf400, 16'h0001, 16'h0000, 10'h27f, 4'hf, 16'h1234},
    '{16'hfda5, 16'h00fe, 16'h0000, 10'h37f, 4'hf, 16'hbeef},
    '{16'hf010, 16'hfc01, 16'h0000, 10'h17f, 4'hf, 16'h1234},
    '{16'hf011, 16'h0101, 16'h0000, 10'h103, 4'h7, 16'h0002},
    '{16'hf012, 16'h00ff, 16'h0000, 10'h17f, 4'h7, 16'h0003},
    '{16'hf013, 16'h0000, 16'h0000, 10'h17f, 4'h7, 16'h0004},
    '{16'hf014, 16'h0201, 16'h0000, 10'h37f, 4'h7, 16'h0005},
    '{16'hf015, 16'h0001, 16'h0000, 10'h07f, 4'h7, 16'h0006},
    '{16'h6016, 16'h0001, 16'h0000, 10'h17f, 4'h7, 16'h0001}
  };

  ted_text_element_decoder u_ted_text_element_decoder (
    .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp)
  );

  ted_master_model u_ted_master_model (
    .clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hung(hung)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    u_ted_master_model.xfer(1'b0, a, 32'h0, v);
    check(v, exp);
  endtask : rd

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  //////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;

  // a wait that ran out ends the run at once
  always @(posedge hung) begin
    num_errors++;
    give_verdict();
  end

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    num_errors = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      u_ted_master_model.setTask(rows[i].pid, rows[i].index_word, rows[i].val, rows[i].cfg);
      u_ted_master_model.waitDone(st);
      check({29'h0, st[2:0]}, {29'h0, rows[i].id == 4'h7, 2'h2});
      rd(`TED_OFS_RSP_PID, {16'h0, rows[i].id, rows[i].pid[11:0]});
      rd(`TED_OFS_RSP_IND, {16'h0, rows[i].index_word});
      rd(`TED_OFS_RSP_VAL, {16'h0, rows[i].rv});
    end
    // an index write that lands while the task runs must be dropped
    u_ted_master_model.setTask(16'hf020, 16'h0001, 16'h0000, 10'h17f);
    u_ted_master_model.xfer(1'b1, `TED_OFS_TASK_IND, 32'h00fe, d);
    u_ted_master_model.waitDone(st);
    rd(`TED_OFS_RSP_VAL, 32'h1234);
    rd(`TED_OFS_TASK_IND, 32'h0001);
    // second reset in mid-run
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check({30'h0, hreadyout, hresp}, 32'h2);
    check(hrdata, 32'h0);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(`TED_OFS_CFG, 32'h17f);
    rd(`TED_OFS_TASK_PID, 32'h0);
    rd(`TED_OFS_STATUS, 32'h0);
    rd(`TED_OFS_CMD, 32'h0);
    rd(8'h40, 32'h0);
    check({31'h0, hresp}, 32'h0);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire

// >>> verif/ted_master_model.sv
// Purpose: ahb-lite master that issues parameter tasks to the decoder
// Assumes: every task is entered right after a rising edge
// Notes:   a bounded wait that runs out raises hung
`timescale 1ns/1ps
`default_nettype none
`include "ted_map.svh"

module ted_master_model (
  // clock
  input  wire logic        clk,
  // ahb-lite master side
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // bench status
  output var  logic        hung
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hung = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic waitRdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) begin
      hung <= 1'b1;
    end
  endtask : waitRdy

  // one whole word; read data is taken at the edge that ends the data phase
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    // a read inverts the word left on the write bus
    hwdata <= wr ? wd : ~hwdata;
    waitRdy();
    rd = hrdata;
  endtask : xfer

  // go is written last so the task words are whole when it is taken
  task automatic setTask(input logic [15:0] pid, index_word, val, input logic [9:0] cfg);
    logic [31:0] d;
    xfer(1'b1, `TED_OFS_TASK_PID, {16'h0, pid}, d);
    xfer(1'b1, `TED_OFS_TASK_IND, {16'h0, index_word}, d);
    xfer(1'b1, `TED_OFS_TASK_VAL, {16'h0, val}, d);
    xfer(1'b1, `TED_OFS_CFG, {22'h0, cfg}, d);
    xfer(1'b1, `TED_OFS_CMD, 32'h1, d);
  endtask : setTask

  // poll until done, keep that status word, then clear done
  task automatic waitDone(output logic [31:0] st);
    logic [31:0] d;
    int n;
    n = 0;
    do begin
      xfer(1'b0, `TED_OFS_STATUS, 32'h0, st);
      n++;
    end while (st[1] !== 1'b1 && n < 16);
    if (st[1] !== 1'b1) begin
      hung <= 1'b1;
    end
    xfer(1'b1, `TED_OFS_CMD, 32'h2, d);
  endtask : waitDone
endmodule : ted_master_model
`default_nettype wire
